//--- common/mtc_pkg.sv
// mtc_pkg: constants and carrier types of the memory translation and context block.
// assumes one core clock; coprocessor transfers and core accesses arrive as structs.
package mtc_pkg;
  localparam int unsigned SETS    = 32;
  localparam int unsigned WAYS    = 2;
  localparam int unsigned LOCKS   = 8;
  localparam int unsigned IDX_LSB = 20;
  localparam int unsigned TAG_LSB = 10;
  localparam int unsigned L2_MSB  = 19;
  localparam int unsigned CRS_LSB = 12;
  localparam int unsigned FIN_LSB = 10;
  localparam int unsigned FSR_W   = 8;
  // coprocessor register numbers and selectors
  localparam logic [3:0] CRN_CTRL = 4'h1;
  localparam logic [3:0] CRN_TTB  = 4'h2;
  localparam logic [3:0] CRN_DAC  = 4'h3;
  localparam logic [3:0] CRN_FSR  = 4'h5;
  localparam logic [3:0] CRN_FAR  = 4'h6;
  localparam logic [3:0] CRN_TLBO = 4'h8;
  localparam logic [3:0] CRN_LOCK = 4'hA;
  localparam logic [3:0] CRN_PID  = 4'hD;
  localparam logic [2:0] OP2_A    = 3'h0;
  localparam logic [2:0] OP2_B    = 3'h1;
  // field positions
  localparam int unsigned M_BIT   = 0;
  localparam int unsigned A_BIT   = 1;
  localparam int unsigned S_BIT   = 8;
  localparam int unsigned R_BIT   = 9;
  localparam int unsigned TTB_LSB = 14;
  localparam int unsigned PID_LSB = 25;
  localparam int unsigned VIC_LSB = 26;
  localparam int unsigned P_BIT   = 0;
  localparam int unsigned DOM_LSB = 5;
  localparam int unsigned SAP_LSB = 10;
  localparam int unsigned PAP_LSB = 4;
  localparam int unsigned CB_LSB  = 2;
  localparam int unsigned LSUB    = 14;
  localparam int unsigned SSUB    = 10;
  localparam logic [1:0]  FETCH_LAG = 2'h2;
  // mapping sizes and tag masks
  localparam logic [1:0]  SZ_SEC  = 2'h0;
  localparam logic [1:0]  SZ_LRG  = 2'h1;
  localparam logic [1:0]  SZ_SML  = 2'h2;
  localparam logic [1:0]  SZ_TNY  = 2'h3;
  localparam logic [21:0] MSK_SEC = 22'h3FFC00;
  localparam logic [21:0] MSK_LRG = 22'h3FFFC0;
  localparam logic [21:0] MSK_SML = 22'h3FFFFC;
  localparam logic [21:0] MSK_TNY = 22'h3FFFFF;
  // descriptor types (level one: coarse, section, fine; level two: large, small, tiny)
  localparam logic [1:0]  DT_FLT  = 2'h0;
  localparam logic [1:0]  DT_ONE  = 2'h1;
  localparam logic [1:0]  DT_TWO  = 2'h2;
  localparam logic [1:0]  DT_THR  = 2'h3;
  // domain modes and access permission codes
  localparam logic [1:0]  DOM_CLIENT = 2'h1;
  localparam logic [1:0]  DOM_MGR    = 2'h3;
  localparam logic [1:0]  AP_NONE = 2'h0;
  localparam logic [1:0]  AP_PRIV = 2'h1;
  localparam logic [1:0]  AP_URO  = 2'h2;
  // fault codes
  localparam logic [3:0]  FLT_ALIGN = 4'h1;
  localparam logic [3:0]  FLT_TSEC  = 4'h5;
  localparam logic [3:0]  FLT_TPG   = 4'h7;
  localparam logic [3:0]  FLT_DSEC  = 4'h9;
  localparam logic [3:0]  FLT_DPG   = 4'hB;
  localparam logic [3:0]  FLT_PSEC  = 4'hD;
  localparam logic [3:0]  FLT_PPG   = 4'hF;
  localparam logic [1:0]  ACC_HALF  = 2'h1;
  localparam logic [1:0]  ACC_WORD  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_CHECK = 2'b01, ST_WALK1 = 2'b11, ST_WALK2 = 2'b10
  } mtc_state_e_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  size;
    logic [21:0] vtag;
    logic [21:0] ptag;
    logic [3:0]  dom;
    logic [7:0]  ap;
    logic [1:0]  cb;
  } mtc_entry_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  crn;
    logic [2:0]  op2;
    logic [31:0] wdata;
  } mtc_cp_req_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic        priv;
    logic        onchip;
    logic [1:0]  size;
    logic [31:0] va;
  } mtc_acc_req_t;

  typedef struct packed {
    logic        done;
    logic        abort;
    logic        ext;
    logic [3:0]  fault;
    logic [1:0]  cb;
    logic [31:0] pa;
  } mtc_acc_rsp_t;

  typedef struct packed {
    mtc_state_e_t                       st;
    logic                               m, a, s, r;
    logic [17:0]                        ttb;
    logic [31:0]                        dac;
    logic [7:0]                         dfsr, ifsr;
    logic [31:0]                        far;
    logic [2:0]                         vic;
    logic                               pres;
    logic [6:0]                         pid, pid_old;
    logic [1:0]                         hold;
    logic [31:0]                        ctx;
    logic                               ctx_wr;
    logic [31:0]                        rdata;
    mtc_acc_req_t                       req;
    logic [31:0]                        relocated_virtual_address;
    logic [3:0]                         l1dom;
    logic [31:0]                        waddr;
    mtc_acc_rsp_t                       rsp;
    mtc_entry_t [SETS-1:0][WAYS-1:0]    tlb;
    mtc_entry_t [LOCKS-1:0]             lk;
    logic [SETS-1:0]                    rr;
  } mtc_state_t;
endpackage : mtc_pkg

//--- hdl/mtc_mmu.sv
// mtc_mmu: address relocation, unified translation buffer, table walk, permission
// checks, coprocessor registers and trace process tag.
// assumes the core holds a request until ready and the walk memory answers with ack.
// Overview of operation
// - relocation identifier write needs no buffer flush
// - two fetches after write use old identifier
// - context register always drives process tag pins
// - context register write pulses tag strobe once
// - one unified buffer serves fetches and data
// - main buffer two ways of thirty-two
// - eight-entry fully associative lockdown buffer
// - sections, large, small and tiny pages
// - large and small pages have quarter permissions
// - sixteen domains: check, allow or abort
// - hit: physical address, on-chip service, or abort
// - miss starts walk and fills the buffer
// - lock control register steers fill location
// - reset leaves translation off, uncached, unbuffered
// - domain register holds sixteen two-bit fields
// - fault status holds domain and type
// - fault address holds relocated data abort address
// - aborts update fault status; data aborts also update fault address
// - maintenance register write-only, invalidates all/one
// - control holds enable, alignment, protection bits
// - addresses below 32MB get identifier offset while translation is on
// - preserve fill uses victim, victim increments
// - invalidate all keeps lockdown entries
module mtc_mmu (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // coprocessor transfers
  input  wire mtc_pkg::mtc_cp_req_t  i_cp,
  output logic [31:0]                o_cp_rdata,
  // core accesses
  input  wire mtc_pkg::mtc_acc_req_t i_acc,
  output logic                       o_acc_ready,
  output mtc_pkg::mtc_acc_rsp_t      o_acc,
  // table walk memory
  output logic                       o_walk_req,
  output logic [31:0]                o_walk_addr,
  input  wire logic                  i_walk_ack,
  input  wire logic [31:0]           i_walk_data,
  // trace
  output logic [31:0]                o_process_tag_out,
  output logic                       o_process_tag_write_strobe
);
  mtc_pkg::mtc_state_t q, n;
  logic [mtc_pkg::LOCKS-1:0] lk_hit;
  logic [mtc_pkg::WAYS-1:0]  way_hit;
  logic [4:0]                idx;
  logic                      cp_wr, pid_wr, ctx_wr, acc_fire;
  logic                      fin, ab, fill, inv_all, inv_one, align_bad, any_hit;
  logic [3:0]                fc, fd;
  logic [1:0]                cbv, dm;
  logic [31:0]               pav;
  mtc_pkg::mtc_entry_t       fe, he;
  logic [6:0]                pid_now;

  function automatic logic [21:0] size_mask(input logic [1:0] sz);
    case (sz)
      mtc_pkg::SZ_SEC: size_mask = mtc_pkg::MSK_SEC;
      mtc_pkg::SZ_LRG: size_mask = mtc_pkg::MSK_LRG;
      mtc_pkg::SZ_SML: size_mask = mtc_pkg::MSK_SML;
      default:         size_mask = mtc_pkg::MSK_TNY;
    endcase
  endfunction : size_mask

  function automatic logic ent_hit(input mtc_pkg::mtc_entry_t e, input logic [31:0] a);
    ent_hit = e.valid && (((e.vtag ^ a[31:mtc_pkg::TAG_LSB]) & size_mask(e.size)) == '0);
  endfunction : ent_hit

  // quarter permissions for large and small pages
  function automatic logic [1:0] sub_ap(input mtc_pkg::mtc_entry_t e, input logic [31:0] a);
    case (e.size)
      mtc_pkg::SZ_LRG: sub_ap = e.ap[{a[mtc_pkg::LSUB +: 2], 1'b0} +: 2];
      mtc_pkg::SZ_SML: sub_ap = e.ap[{a[mtc_pkg::SSUB +: 2], 1'b0} +: 2];
      default:         sub_ap = e.ap[1:0];
    endcase
  endfunction : sub_ap

  function automatic logic perm_ok(input logic [1:0] ap, input logic s, input logic r,
                                   input logic priv, input logic wr);
    case (ap)
      mtc_pkg::AP_NONE: perm_ok = !wr && ((s && priv) || r);
      mtc_pkg::AP_PRIV: perm_ok = priv;
      mtc_pkg::AP_URO:  perm_ok = priv || !wr;
      default:          perm_ok = 1'b1;
    endcase
  endfunction : perm_ok

  function automatic mtc_pkg::mtc_entry_t mk(input logic [1:0] sz, input logic [31:0] a,
                                             input logic [31:0] d, input logic [3:0] dom,
                                             input logic [7:0] ap);
    mk.valid = 1'b1;
    mk.size  = sz;
    mk.vtag  = a[31:mtc_pkg::TAG_LSB];
    mk.ptag  = d[31:mtc_pkg::TAG_LSB];
    mk.dom   = dom;
    mk.ap    = ap;
    mk.cb    = d[mtc_pkg::CB_LSB +: 2];
  endfunction : mk

  assign cp_wr    = i_cp.valid && i_cp.write;
  assign pid_wr   = cp_wr && i_cp.crn == mtc_pkg::CRN_PID && i_cp.op2 == mtc_pkg::OP2_A;
  assign ctx_wr   = cp_wr && i_cp.crn == mtc_pkg::CRN_PID && i_cp.op2 == mtc_pkg::OP2_B;
  assign acc_fire = q.st == mtc_pkg::ST_IDLE && i_acc.valid;
  assign idx      = q.relocated_virtual_address[mtc_pkg::IDX_LSB +: 5];
  assign pid_now  = (q.hold == '0) ? q.pid : q.pid_old;
  assign align_bad = q.a && !q.req.fetch &&
                     ((q.req.size == mtc_pkg::ACC_HALF && q.relocated_virtual_address[0]) ||
                      (q.req.size == mtc_pkg::ACC_WORD && q.relocated_virtual_address[1:0] != '0));

  // unified lookup, one set of two ways plus the lockdown entries
  genvar gi;
  generate
    for (gi = 0; gi < mtc_pkg::LOCKS; gi++) begin : g_lk
      assign lk_hit[gi] = ent_hit(q.lk[gi], q.relocated_virtual_address);
    end
    for (gi = 0; gi < mtc_pkg::WAYS; gi++) begin : g_way
      assign way_hit[gi] = ent_hit(q.tlb[idx][gi], q.relocated_virtual_address);
    end
  endgenerate
  assign any_hit = (lk_hit != '0) || (way_hit != '0);

  always_comb begin
    n = q;
    n.ctx_wr = 1'b0;
    n.rsp.done = 1'b0;
    fin = 1'b0;
    ab = 1'b0;
    fc = '0;
    fd = '0;
    fill = 1'b0;
    fe = '0;
    he = '0;
    dm = '0;
    cbv = '0;
    pav = q.relocated_virtual_address;
    inv_all = cp_wr && i_cp.crn == mtc_pkg::CRN_TLBO && i_cp.op2 == mtc_pkg::OP2_A;
    inv_one = cp_wr && i_cp.crn == mtc_pkg::CRN_TLBO && i_cp.op2 == mtc_pkg::OP2_B;
    for (int i = mtc_pkg::WAYS - 1; i >= 0; i--) begin
      if (way_hit[i]) he = q.tlb[idx][i];
    end
    for (int i = mtc_pkg::LOCKS - 1; i >= 0; i--) begin
      if (lk_hit[i]) he = q.lk[i];
    end
    case (q.st)
      mtc_pkg::ST_IDLE: begin
        if (i_acc.valid) begin
          n.req = i_acc;
          n.relocated_virtual_address = i_acc.va;
          // relocate the low 32MB only while translation is on
          if (q.m && i_acc.va[31:mtc_pkg::PID_LSB] == '0) begin
            n.relocated_virtual_address[31:mtc_pkg::PID_LSB] = i_acc.fetch ? pid_now : q.pid;
          end
          if (i_acc.fetch && q.hold != '0) n.hold = q.hold - 2'h1;
          n.st = mtc_pkg::ST_CHECK;
        end
      end
      mtc_pkg::ST_CHECK: begin
        if (align_bad) begin
          ab = 1'b1;
          fc = mtc_pkg::FLT_ALIGN;
        end else if (!q.m) begin
          fin = 1'b1; // flat, uncached, unbuffered
        end else if (any_hit) begin
          fd = he.dom;
          dm = q.dac[{he.dom, 1'b0} +: 2];
          cbv = he.cb;
          pav[31:mtc_pkg::TAG_LSB] = (he.ptag & size_mask(he.size)) |
                                     (q.relocated_virtual_address[31:mtc_pkg::TAG_LSB] & ~size_mask(he.size));
          if (dm == mtc_pkg::DOM_MGR) begin
            fin = 1'b1;
          end else if (dm == mtc_pkg::DOM_CLIENT) begin
            if (perm_ok(sub_ap(he, q.relocated_virtual_address), q.s, q.r, q.req.priv, q.req.write)) fin = 1'b1;
            else begin
              ab = 1'b1;
              fc = (he.size == mtc_pkg::SZ_SEC) ? mtc_pkg::FLT_PSEC : mtc_pkg::FLT_PPG;
            end
          end else begin
            ab = 1'b1;
            fc = (he.size == mtc_pkg::SZ_SEC) ? mtc_pkg::FLT_DSEC : mtc_pkg::FLT_DPG;
          end
        end else begin
          n.waddr = {q.ttb, q.relocated_virtual_address[31:mtc_pkg::IDX_LSB], 2'h0};
          n.st = mtc_pkg::ST_WALK1;
        end
      end
      mtc_pkg::ST_WALK1: begin
        if (i_walk_ack) begin
          n.l1dom = i_walk_data[mtc_pkg::DOM_LSB +: 4];
          case (i_walk_data[1:0])
            mtc_pkg::DT_TWO: begin
              fill = 1'b1; // section
              fe = mk(mtc_pkg::SZ_SEC, q.relocated_virtual_address, i_walk_data, n.l1dom,
                      8'(i_walk_data[mtc_pkg::SAP_LSB +: 2]));
              n.st = mtc_pkg::ST_CHECK;
            end
            mtc_pkg::DT_ONE: begin
              n.waddr = {i_walk_data[31:mtc_pkg::TAG_LSB],
                         q.relocated_virtual_address[mtc_pkg::L2_MSB:mtc_pkg::CRS_LSB], 2'h0};
              n.st = mtc_pkg::ST_WALK2;
            end
            mtc_pkg::DT_THR: begin
              n.waddr = {i_walk_data[31:mtc_pkg::CRS_LSB],
                         q.relocated_virtual_address[mtc_pkg::L2_MSB:mtc_pkg::FIN_LSB], 2'h0};
              n.st = mtc_pkg::ST_WALK2;
            end
            default: begin
              ab = 1'b1;
              fc = mtc_pkg::FLT_TSEC;
              fd = n.l1dom;
            end
          endcase
        end
      end
      mtc_pkg::ST_WALK2: begin
        if (i_walk_ack) begin
          n.st = mtc_pkg::ST_CHECK;
          fill = 1'b1;
          case (i_walk_data[1:0])
            mtc_pkg::DT_ONE: fe = mk(mtc_pkg::SZ_LRG, q.relocated_virtual_address, i_walk_data, q.l1dom,
                                     i_walk_data[mtc_pkg::PAP_LSB +: 8]);
            mtc_pkg::DT_TWO: fe = mk(mtc_pkg::SZ_SML, q.relocated_virtual_address, i_walk_data, q.l1dom,
                                     i_walk_data[mtc_pkg::PAP_LSB +: 8]);
            mtc_pkg::DT_THR: fe = mk(mtc_pkg::SZ_TNY, q.relocated_virtual_address, i_walk_data, q.l1dom,
                                     8'(i_walk_data[mtc_pkg::PAP_LSB +: 2]));
            default: begin
              fill = 1'b0;
              ab = 1'b1;
              fc = mtc_pkg::FLT_TPG;
              fd = q.l1dom;
            end
          endcase
        end
      end
      default: n.st = mtc_pkg::ST_IDLE;
    endcase

    // coprocessor writes
    if (cp_wr) begin
      case (i_cp.crn)
        mtc_pkg::CRN_CTRL: begin
          n.m = i_cp.wdata[mtc_pkg::M_BIT];
          n.a = i_cp.wdata[mtc_pkg::A_BIT];
          n.s = i_cp.wdata[mtc_pkg::S_BIT];
          n.r = i_cp.wdata[mtc_pkg::R_BIT];
        end
        mtc_pkg::CRN_TTB:  n.ttb = i_cp.wdata[31:mtc_pkg::TTB_LSB];
        mtc_pkg::CRN_DAC:  n.dac = i_cp.wdata;
        mtc_pkg::CRN_FSR: begin
          if (i_cp.op2 == mtc_pkg::OP2_B) n.ifsr = i_cp.wdata[mtc_pkg::FSR_W-1:0];
          else n.dfsr = i_cp.wdata[mtc_pkg::FSR_W-1:0];
        end
        mtc_pkg::CRN_FAR:  n.far = i_cp.wdata;
        mtc_pkg::CRN_LOCK: begin
          n.vic  = i_cp.wdata[mtc_pkg::VIC_LSB +: 3];
          n.pres = i_cp.wdata[mtc_pkg::P_BIT];
        end
        mtc_pkg::CRN_PID: begin
          if (pid_wr) begin
            // stored tags stay valid, so nothing is flushed
            n.pid_old = pid_now;
            n.pid     = i_cp.wdata[mtc_pkg::PID_LSB +: 7];
            n.hold    = mtc_pkg::FETCH_LAG;
          end else begin
            n.ctx    = i_cp.wdata;
            n.ctx_wr = 1'b1;
          end
        end
        default: ; // reserved register writes dropped; maintenance writes handled below
      endcase
    end

    // coprocessor reads, answered next cycle
    n.rdata = '0;
    if (i_cp.valid && !i_cp.write) begin
      case (i_cp.crn)
        mtc_pkg::CRN_CTRL: n.rdata = (32'(q.m) << mtc_pkg::M_BIT) | (32'(q.a) << mtc_pkg::A_BIT)
                                   | (32'(q.s) << mtc_pkg::S_BIT) | (32'(q.r) << mtc_pkg::R_BIT);
        mtc_pkg::CRN_TTB:  n.rdata = 32'(q.ttb) << mtc_pkg::TTB_LSB;
        mtc_pkg::CRN_DAC:  n.rdata = q.dac;
        mtc_pkg::CRN_FSR:  n.rdata = (i_cp.op2 == mtc_pkg::OP2_B) ? 32'(q.ifsr) : 32'(q.dfsr);
        mtc_pkg::CRN_FAR:  n.rdata = q.far;
        mtc_pkg::CRN_LOCK: n.rdata = (32'(q.vic) << mtc_pkg::VIC_LSB) | 32'(q.pres);
        mtc_pkg::CRN_PID:  n.rdata = (i_cp.op2 == mtc_pkg::OP2_B) ? q.ctx :
                                     32'(q.pid) << mtc_pkg::PID_LSB;
        default: n.rdata = '0; // write-only maintenance and reserved read zero
      endcase
    end

    // fill after a walk, lockdown slot or round-robin way
    if (fill) begin
      if (q.pres) begin
        n.lk[q.vic] = fe;
        n.vic = q.vic + 3'h1;
      end else begin
        n.tlb[idx][q.rr[idx]] = fe;
        n.rr[idx] = ~q.rr[idx];
      end
    end

    // maintenance operations
    if (inv_all) begin
      for (int s = 0; s < mtc_pkg::SETS; s++) begin
        for (int w = 0; w < mtc_pkg::WAYS; w++) n.tlb[s][w].valid = 1'b0;
      end
    end
    if (inv_one) begin
      for (int w = 0; w < mtc_pkg::WAYS; w++) begin
        if (ent_hit(n.tlb[i_cp.wdata[mtc_pkg::IDX_LSB +: 5]][w], i_cp.wdata)) begin
          n.tlb[i_cp.wdata[mtc_pkg::IDX_LSB +: 5]][w].valid = 1'b0;
        end
      end
      for (int i = 0; i < mtc_pkg::LOCKS; i++) begin
        if (ent_hit(n.lk[i], i_cp.wdata)) n.lk[i].valid = 1'b0;
      end
    end

    // completion; hardware fault capture wins over a same-cycle software write
    if (fin || ab) begin
      n.st        = mtc_pkg::ST_IDLE;
      n.rsp.done  = 1'b1;
      n.rsp.abort = ab;
      n.rsp.ext   = !ab && !q.req.onchip;
      n.rsp.fault = fc;
      n.rsp.cb    = ab ? 2'h0 : cbv;
      n.rsp.pa    = ab ? 32'h0 : pav;
      if (ab) begin
        if (q.req.fetch) n.ifsr = {fd, fc};
        else begin
          n.dfsr = {fd, fc};
          n.far  = q.relocated_virtual_address;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) q <= '0;
    else q <= n;
  end

  assign o_cp_rdata                 = q.rdata;
  assign o_acc_ready                = q.st == mtc_pkg::ST_IDLE;
  assign o_acc                      = q.rsp;
  assign o_walk_req                 = q.st == mtc_pkg::ST_WALK1 || q.st == mtc_pkg::ST_WALK2;
  assign o_walk_addr                = q.waddr;
  assign o_process_tag_out          = q.ctx;
  assign o_process_tag_write_strobe = q.ctx_wr;

  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_miss;
    q.st == mtc_pkg::ST_CHECK && q.m && !any_hit && !align_bad;
  endsequence
  sequence s_low_fetch;
    acc_fire && i_acc.fetch && q.m && q.hold != '0 && i_acc.va[31:mtc_pkg::PID_LSB] == '0;
  endsequence

  chk_tag_mirror: assert property (
    ctx_wr |=> o_process_tag_out == $past(i_cp.wdata)) else $error("tag pins stale");
  chk_tag_strobe: assert property (
    ctx_wr |=> o_process_tag_write_strobe ##1 (o_process_tag_write_strobe == $past(ctx_wr)))
    else $error("tag strobe wrong");
  chk_fetch_lag: assert property (
    s_low_fetch |=> q.relocated_virtual_address[31:mtc_pkg::PID_LSB] == $past(q.pid_old))
    else $error("fetch used new identifier early");
  chk_reloc_data: assert property (
    acc_fire && !i_acc.fetch && q.m && i_acc.va[31:mtc_pkg::PID_LSB] == '0
    |=> q.relocated_virtual_address == {$past(q.pid), $past(i_acc.va[mtc_pkg::PID_LSB-1:0])})
    else $error("relocation wrong");
  chk_walk_start: assert property (
    s_miss |=> o_walk_req && o_walk_addr[31:mtc_pkg::TTB_LSB] == $past(q.ttb))
    else $error("miss did not walk");
  chk_abort_quiet: assert property (
    o_acc.done && o_acc.abort |-> !o_acc.ext && o_acc.pa == '0 && o_acc.cb == '0)
    else $error("aborted access went out");
  chk_fsr_capture: assert property (
    ab && !q.req.fetch |=> q.dfsr == {$past(fd), $past(fc)} && q.far == $past(q.relocated_virtual_address))
    else $error("fault not recorded");
  chk_victim_step: assert property (
    fill && q.pres |=> q.vic == $past(q.vic) + 3'h1 && q.lk[$past(q.vic)].valid)
    else $error("victim not advanced");
  chk_inval_lock: assert property (
    inv_all && !fill && !inv_one |=> q.lk == $past(q.lk) && q.tlb[0][0].valid == 1'b0)
    else $error("invalidate all wrong");
  chk_off_flat: assert property (
    q.st == mtc_pkg::ST_CHECK && !q.m && !align_bad
    |=> o_acc.done && o_acc.pa == $past(q.req.va) && o_acc.cb == '0)
    else $error("flat mapping wrong");
endmodule : mtc_mmu

//--- testbench/mtc_walk_mem.sv
// mtc_walk_mem: walk memory model, answers every read with a section descriptor.
// assumes the request holds until ack; i_lat sets the answer delay.
module mtc_walk_mem (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_lat,
  output logic             o_ack,
  output logic [31:0]      o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]  n;
  logic [31:0] last;
  // domain 0, full access, cached; base flips the top address bit
  wire  [31:0] desc = {i_addr[13:2] ^ 12'h800, 20'h00C1E};
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      n <= 2'h0;
      o_ack <= 1'b0;
      last <= 32'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_req && !o_ack && n == i_lat) begin
        o_ack <= 1'b1;
        n <= 2'h0;
        last <= desc;
      end else if (i_req && !o_ack) n <= n + 2'h1;
    end
  end
  // a released bus shows the inverse of the last word
  assign o_data = o_ack ? desc : ~last;
endmodule : mtc_walk_mem

//--- testbench/mtc_mmu_tb_top.sv
// mtc_mmu_tb_top: self-checking bench for mtc_mmu.
// assumes a 200 MHz clock and section mappings from mtc_walk_mem.
module mtc_mmu_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, rdy, wreq, wack, stb, rd_d = 0;
  mtc_pkg::mtc_cp_req_t  cp = '0;
  mtc_pkg::mtc_acc_req_t ac = '0;
  mtc_pkg::mtc_acc_rsp_t rsp;
  logic [31:0] rdat, tag, wad, wdat, t, x = 32'h58;
  int fail_count = 0, total_checks = 0, walks = 0, cyc = 0, w;
  logic [39:0] rq[$], aq[$];
  always #2.5 clk = ~clk;
  mtc_mmu dut_u (.i_clk(clk), .i_sys_rst(rst), .i_cp(cp), .o_cp_rdata(rdat), .i_acc(ac),
    .o_acc_ready(rdy), .o_acc(rsp), .o_walk_req(wreq), .o_walk_addr(wad), .i_walk_ack(wack),
    .i_walk_data(wdat), .o_process_tag_out(tag), .o_process_tag_write_strobe(stb));
  mtc_walk_mem mem_u (.i_clk(clk), .i_sys_rst(rst), .i_req(wreq), .i_addr(wad),
    .i_lat(x[1:0]), .o_ack(wack), .o_data(wdat));
  function automatic logic [31:0] rnd();
    x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction : rnd
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic cpx(input logic wr, input logic [3:0] c, input logic [2:0] o,
                     input logic [31:0] d);
    @(posedge clk);
    #1 cp = '{1'b1, wr, c, o, d};
    @(posedge clk);
    #1 cp.valid = 1'b0;
  endtask : cpx
  task automatic rd(input logic [3:0] c, input logic [2:0] o, input logic [31:0] e);
    rq.push_back({8'h0, e});
    cpx(1'b0, c, o, 32'h0);
  endtask : rd
  // expected response: cb, abort, ext, fault, physical address
  function automatic logic [39:0] ok(input logic [31:0] m, input logic on);
    return {2'h3, 1'b0, !on, 4'h0, m[31:20] ^ 12'h800, m[19:0]};
  endfunction : ok
  task automatic acc(input logic f, input logic [31:0] va, input logic on,
                     input logic [39:0] e);
    aq.push_back(e);
    @(posedge clk);
    #1 ac = '{1'b1, f, 1'b0, 1'b1, on, 2'h2, va};
    do @(posedge clk); while (rdy !== 1'b1);
    #1 ac.valid = 1'b0;
    while (rsp.done !== 1'b1) @(posedge clk);
  endtask : acc
  always @(posedge clk) begin
    cyc++;
    if (wreq && wack) walks++;
    if (rd_d) chk({8'h0, rdat}, rq.pop_front());
    if (rsp.done === 1'b1) chk({rsp.cb, rsp.abort, rsp.ext, rsp.fault, rsp.pa}, aq.pop_front());
    rd_d <= cp.valid & !cp.write;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    rd(mtc_pkg::CRN_CTRL, 3'h0, 32'h0);
    rd(mtc_pkg::CRN_LOCK, 3'h0, 32'h0);
    $display("test reset done");
    t = rnd();
    cpx(1'b1, mtc_pkg::CRN_PID, mtc_pkg::OP2_B, t);
    chk({7'h0, stb, tag}, {7'h1, t});
    @(posedge clk);
    #1 chk({39'h0, stb}, 40'h0);
    rd(mtc_pkg::CRN_PID, mtc_pkg::OP2_B, t);
    cpx(1'b1, 4'hE, 3'h0, rnd());
    rd(4'hE, 3'h0, 32'h0);
    rd(mtc_pkg::CRN_TLBO, 3'h0, 32'h0);
    t = rnd();
    acc(1'b0, t, t[0], {3'h0, !t[0], 4'h0, t});
    $display("test context done");
    cpx(1'b1, mtc_pkg::CRN_TTB, 3'h0, 32'h0001C000);
    cpx(1'b1, mtc_pkg::CRN_DAC, 3'h0, 32'h1);
    cpx(1'b1, mtc_pkg::CRN_CTRL, 3'h0, 32'h1);
    acc(1'b0, 32'h00300010, 1'b0, ok(32'h00300010, 1'b0));
    w = walks;
    acc(1'b1, 32'h00300010, 1'b1, ok(32'h00300010, 1'b1));
    chk(40'(walks - w), 40'h0);
    cpx(1'b1, mtc_pkg::CRN_PID, mtc_pkg::OP2_A, 32'h02000000);
    for (int i = 0; i < 3; i++)
      acc(1'b1, 32'h00400000, 1'b0, ok(i < 2 ? 32'h00400000 : 32'h02400000, 1'b0));
    acc(1'b0, 32'h01000004, 1'b0, ok(32'h03000004, 1'b0));
    $display("test relocation done");
    cpx(1'b1, mtc_pkg::CRN_DAC, 3'h0, 32'h0);
    acc(1'b0, 32'h00500000, 1'b0, {4'h2, mtc_pkg::FLT_DSEC, 32'h0});
    acc(1'b1, 32'h00600000, 1'b0, {4'h2, mtc_pkg::FLT_DSEC, 32'h0});
    rd(mtc_pkg::CRN_FSR, mtc_pkg::OP2_A, 32'h9);
    rd(mtc_pkg::CRN_FSR, mtc_pkg::OP2_B, 32'h9);
    rd(mtc_pkg::CRN_FAR, 3'h0, 32'h02500000);
    cpx(1'b1, mtc_pkg::CRN_DAC, 3'h0, 32'h3);
    acc(1'b0, 32'h00500000, 1'b0, ok(32'h02500000, 1'b0));
    $display("test domain done");
    cpx(1'b1, mtc_pkg::CRN_LOCK, 3'h0, 32'h1);
    acc(1'b0, 32'h00700000, 1'b0, ok(32'h02700000, 1'b0));
    rd(mtc_pkg::CRN_LOCK, 3'h0, 32'h04000001);
    cpx(1'b1, mtc_pkg::CRN_LOCK, 3'h0, 32'h0);
    cpx(1'b1, mtc_pkg::CRN_TLBO, mtc_pkg::OP2_A, 32'h0);
    w = walks;
    acc(1'b0, 32'h00700000, 1'b0, ok(32'h02700000, 1'b0));
    chk(40'(walks - w), 40'h0);
    acc(1'b1, 32'h00400000, 1'b0, ok(32'h02400000, 1'b0));
    chk(40'(walks - w), 40'h1);
    $display("test lockdown done");
    @(posedge clk);
    conclude();
  end
endmodule : mtc_mmu_tb_top
